// ---- design/cmmd_decoder.sv ----
/*
  CPU memory map decoder with reset vector loader, program counter and
  processor status word. Holds the memory size selection setting.
  Assumes a single 100 MHz clock, a synchronous active-high reset, and a
  sequencer on the same clock that returns memory read data one cycle after
  a vector read request.
*/
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Unified 64 KB space, 16-bit addresses
// - Memory size setting resets to CFH
// - Flash block number is address bits 14..10
// - Lowest 64 bytes are the vector table
// - Vectors little-endian, low byte at even
// - All reset sources share vector 0000H
// - Each interrupt has even two-byte vector
// - 0040H-007FH is the table-call entry table
// - Option bytes 0080H-0084H, swap copy 1080H
// - 0800H-0FFFH reachable by short call
// - Security ID 0085H-008EH, swap copy 1085H
// - RAM ends FEFFH, start set by capacity
// - Top 32 RAM bytes are four banks
// - No fetch from register bank region
// - RAM usable as stack memory
// - FF00H-FFFFH is the peripheral register window
// - Pointer advances by length or loads branch
// - Reset loads pointer from 0000H and 0001H
// - Status word saved and restored via stack
// - Reset sets status word to 02H
module cmmd_decoder #(
  parameter bit DEBUG_VARIANT = 1'b1
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire cmmd_pkg::cmmd_req_t   req_in,
  input  wire cmmd_pkg::cmmd_ctrl_t  ctrl_in,
  input  wire logic                  boot_swap_in,
  input  wire logic                  mss_write_in,
  input  wire logic [7:0]            mss_data_in,
  input  wire logic [7:0]            rd_data_in,
  output var  cmmd_pkg::cmmd_decode_t decode_out,
  output logic                       vec_rd_out,
  output logic [15:0]                vec_addr_out,
  output logic                       ready_out,
  output logic [15:0]                next_instruction_pointer_out,
  output logic [7:0]                 processor_status_word_out,
  output logic [7:0]                 psw_push_data_out,
  output logic [7:0]                 memory_size_select_out
);

  // ****************************************************************
  // Memory size selection
  // ****************************************************************
  logic [7:0]  memory_size_select;
  logic [7:0]  next_memory_size_select;
  logic [15:0] rom_end;
  logic [15:0] ram_start;

  always_comb begin
    next_memory_size_select = memory_size_select;
    if (mss_write_in) begin
      next_memory_size_select = mss_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      memory_size_select <= cmmd_pkg::MSS_RESET;
    end else begin
      memory_size_select <= next_memory_size_select;
    end
  end

  // Capacity limits; the reset code maps to the largest part
  always_comb begin
    if (memory_size_select == cmmd_pkg::MSS_8K_512) begin
      rom_end   = cmmd_pkg::ROM_END_8K;
      ram_start = cmmd_pkg::RAM_START_512;
    end else if (memory_size_select == cmmd_pkg::MSS_16K_768) begin
      rom_end   = cmmd_pkg::ROM_END_16K;
      ram_start = cmmd_pkg::RAM_START_768;
    end else if (memory_size_select == cmmd_pkg::MSS_24K_1K) begin
      rom_end   = cmmd_pkg::ROM_END_24K;
      ram_start = cmmd_pkg::RAM_START_1K;
    end else begin
      rom_end   = cmmd_pkg::ROM_END_32K;
      ram_start = cmmd_pkg::RAM_START_1K;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [15:0] a;
  logic [15:0] a_unswap;
  logic        in_swap;

  always_comb begin
    a        = req_in.addr;
    in_swap  = boot_swap_in && (a >= (cmmd_pkg::OPT_FIRST | cmmd_pkg::SWAP_OFFSET))
               && (a <= (cmmd_pkg::SECID_LAST | cmmd_pkg::SWAP_OFFSET));
    a_unswap = in_swap ? (a & ~cmmd_pkg::SWAP_OFFSET) : a;

    decode_out                  = '0;
    decode_out.region           = cmmd_pkg::CMMD_REG_UNMAPPED;
    decode_out.flash_block      = a[cmmd_pkg::BLK_MSB:cmmd_pkg::BLK_LSB];
    decode_out.reg_bank         = ~a[cmmd_pkg::BANK_SEL_MSB:cmmd_pkg::BANK_SEL_LSB];
    decode_out.vector_area      = (a <= cmmd_pkg::VEC_LAST);
    decode_out.table_call_area  = (a >= cmmd_pkg::TCALL_FIRST) && (a <= cmmd_pkg::TCALL_LAST);
    decode_out.option_area      = (a_unswap >= cmmd_pkg::OPT_FIRST)
                                  && (a_unswap <= cmmd_pkg::OPT_LAST);
    decode_out.security_id_area = DEBUG_VARIANT && (a_unswap >= cmmd_pkg::SECID_FIRST)
                                  && (a_unswap <= cmmd_pkg::SECID_LAST);
    decode_out.short_call_area  = (a >= cmmd_pkg::SCALL_FIRST) && (a <= cmmd_pkg::SCALL_LAST);

    if (a >= cmmd_pkg::SFR_FIRST) begin
      decode_out.region      = cmmd_pkg::CMMD_REG_SFR;
      decode_out.implemented = 1'b1;
    end else if (a >= cmmd_pkg::BANK_FIRST) begin
      decode_out.region      = cmmd_pkg::CMMD_REG_BANK;
      decode_out.implemented = 1'b1;
    end else if ((a >= ram_start) && (a <= cmmd_pkg::RAM_END)) begin
      decode_out.region      = cmmd_pkg::CMMD_REG_RAM;
      decode_out.implemented = 1'b1;
    end else if (a <= rom_end) begin
      decode_out.region      = cmmd_pkg::CMMD_REG_ROM;
      decode_out.implemented = 1'b1;
    end
    // Anything else is beyond capacity and stays unimplemented

    decode_out.fetch_fault  = req_in.valid && req_in.fetch
                              && (decode_out.region == cmmd_pkg::CMMD_REG_BANK);
    decode_out.write_enable = req_in.valid && req_in.write && decode_out.implemented
                              && (decode_out.region != cmmd_pkg::CMMD_REG_ROM);
  end

  // ****************************************************************
  // Reset vector load and program counter
  // ****************************************************************
  cmmd_pkg::cmmd_state_t state;
  cmmd_pkg::cmmd_state_t next_state;
  logic [15:0]           pc;
  logic [15:0]           next_pc;
  logic                  vec_pending;
  logic                  next_vec_pending;

  always_comb begin
    next_state       = state;
    next_pc          = pc;
    next_vec_pending = 1'b0;
    case (state)
      cmmd_pkg::CMMD_ST_VEC_LO: begin
        if (vec_pending) begin
          next_pc    = {pc[15:8], rd_data_in};
          next_state = cmmd_pkg::CMMD_ST_VEC_HI;
        end else begin
          next_vec_pending = 1'b1;
        end
      end
      cmmd_pkg::CMMD_ST_VEC_HI: begin
        if (vec_pending) begin
          next_pc    = {rd_data_in, pc[7:0]};
          next_state = cmmd_pkg::CMMD_ST_RUN;
        end else begin
          next_vec_pending = 1'b1;
        end
      end
      default: begin
        if (ctrl_in.branch) begin
          next_pc = ctrl_in.target;
        end else if (ctrl_in.advance) begin
          next_pc = pc + {14'h0000, ctrl_in.length};
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state       <= cmmd_pkg::CMMD_ST_VEC_LO;
      pc          <= 16'h0000;
      vec_pending <= 1'b0;
    end else begin
      state       <= next_state;
      pc          <= next_pc;
      vec_pending <= next_vec_pending;
    end
  end

  always_comb begin
    vec_rd_out   = (state != cmmd_pkg::CMMD_ST_RUN) && !vec_pending;
    vec_addr_out = (state == cmmd_pkg::CMMD_ST_VEC_HI) ? cmmd_pkg::RESET_VEC_HI
                                                       : cmmd_pkg::RESET_VEC_LO;
    ready_out    = (state == cmmd_pkg::CMMD_ST_RUN);
  end

  // ****************************************************************
  // Processor status word
  // ****************************************************************
  logic [7:0] processor_status_word;
  logic [7:0] next_psw;
  logic [7:0] push_data;
  logic [7:0] next_push_data;

  always_comb begin
    next_psw       = processor_status_word;
    next_push_data = push_data;
    if (ctrl_in.psw_save || ctrl_in.irq_accept) begin
      next_push_data = processor_status_word;
    end
    if (ctrl_in.psw_restore) begin
      next_psw = ctrl_in.stack_data;
    end else if (ctrl_in.psw_write) begin
      next_psw = ctrl_in.psw_data;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      processor_status_word       <= cmmd_pkg::PSW_RESET;
      push_data <= 8'h00;
    end else begin
      processor_status_word       <= next_psw;
      push_data <= next_push_data;
    end
  end

  assign next_instruction_pointer_out = pc;
  assign processor_status_word_out    = processor_status_word;
  assign psw_push_data_out            = push_data;
  assign memory_size_select_out       = memory_size_select;

endmodule

`default_nettype wire

// ---- design/cmmd_pkg.sv ----
/*
  Package for the CPU memory map decoder: address map boundaries, memory size
  codes, reset values and the packed structs that carry requests and answers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cmmd_pkg;

  // ****************************************************************
  // Memory size codes and reset values
  // ****************************************************************
  localparam logic [7:0]  MSS_RESET     = 8'hCF;
  localparam logic [7:0]  MSS_8K_512    = 8'h42;
  localparam logic [7:0]  MSS_16K_768   = 8'h04;
  localparam logic [7:0]  MSS_24K_1K    = 8'hC6;
  localparam logic [7:0]  MSS_32K_1K    = 8'hC8;
  localparam logic [7:0]  PSW_RESET     = 8'h02;
  localparam logic [15:0] RESET_VEC_LO  = 16'h0000;
  localparam logic [15:0] RESET_VEC_HI  = 16'h0001;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [15:0] VEC_FIRST     = 16'h0000;
  localparam logic [15:0] VEC_LAST      = 16'h003F;
  localparam logic [15:0] TCALL_FIRST   = 16'h0040;
  localparam logic [15:0] TCALL_LAST    = 16'h007F;
  localparam logic [15:0] OPT_FIRST     = 16'h0080;
  localparam logic [15:0] OPT_LAST      = 16'h0084;
  localparam logic [15:0] SECID_FIRST   = 16'h0085;
  localparam logic [15:0] SECID_LAST    = 16'h008E;
  localparam logic [15:0] SWAP_OFFSET   = 16'h1000;
  localparam logic [15:0] SCALL_FIRST   = 16'h0800;
  localparam logic [15:0] SCALL_LAST    = 16'h0FFF;
  localparam logic [15:0] ROM_END_8K    = 16'h1FFF;
  localparam logic [15:0] ROM_END_16K   = 16'h3FFF;
  localparam logic [15:0] ROM_END_24K   = 16'h5FFF;
  localparam logic [15:0] ROM_END_32K   = 16'h7FFF;
  localparam logic [15:0] RAM_START_512 = 16'hFD00;
  localparam logic [15:0] RAM_START_768 = 16'hFC00;
  localparam logic [15:0] RAM_START_1K  = 16'hFB00;
  localparam logic [15:0] RAM_END       = 16'hFEFF;
  localparam logic [15:0] BANK_FIRST    = 16'hFEE0;
  localparam logic [15:0] SFR_FIRST     = 16'hFF00;
  localparam int          BLK_MSB       = 14;
  localparam int          BLK_LSB       = 10;
  localparam int          BANK_SEL_MSB  = 4;
  localparam int          BANK_SEL_LSB  = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    CMMD_REG_UNMAPPED = 3'b000,
    CMMD_REG_ROM      = 3'b001,
    CMMD_REG_RAM      = 3'b010,
    CMMD_REG_BANK     = 3'b011,
    CMMD_REG_SFR      = 3'b100
  } cmmd_region_t;

  typedef enum logic [1:0] {
    CMMD_ST_VEC_LO = 2'b00,
    CMMD_ST_VEC_HI = 2'b01,
    CMMD_ST_RUN    = 2'b10
  } cmmd_state_t;

  // Access request from the sequencer
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [15:0] addr;
  } cmmd_req_t;

  // Decode answer for the current request
  typedef struct packed {
    cmmd_region_t region;
    logic         implemented;
    logic         write_enable;
    logic         fetch_fault;
    logic         vector_area;
    logic         table_call_area;
    logic         option_area;
    logic         security_id_area;
    logic         short_call_area;
    logic [4:0]   flash_block;
    logic [1:0]   reg_bank;
  } cmmd_decode_t;

  // Program counter and status word controls
  typedef struct packed {
    logic        advance;
    logic [1:0]  length;
    logic        branch;
    logic [15:0] target;
    logic        psw_write;
    logic [7:0]  psw_data;
    logic        psw_save;
    logic        irq_accept;
    logic        psw_restore;
    logic [7:0]  stack_data;
  } cmmd_ctrl_t;

endpackage

// ---- dv/cmmd_assertions.sv ----
/*
  Checker for the memory map decoder: vector load, pointer, status word, decode.
  Assumes it is bound to cmmd_decoder and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module cmmd_assertions (
  input wire logic                   ref_clk_in,
  input wire logic                   rst_in,
  input wire cmmd_pkg::cmmd_req_t    req_in,
  input wire cmmd_pkg::cmmd_ctrl_t   ctrl_in,
  input wire logic                   mss_write_in,
  input wire logic [7:0]             mss_data_in,
  input wire logic [7:0]             rd_data_in,
  input wire cmmd_pkg::cmmd_decode_t decode_out,
  input wire logic                   vec_rd_out,
  input wire logic [15:0]            vec_addr_out,
  input wire logic                   ready_out,
  input wire logic [15:0]            next_instruction_pointer_out,
  input wire logic [7:0]             processor_status_word_out,
  input wire logic [7:0]             psw_push_data_out,
  input wire logic [7:0]             memory_size_select_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ****************************************************************
  // Vector load
  // ****************************************************************
  sequence s_low_byte;
    vec_rd_out && vec_addr_out == 16'h0000 ##1 !vec_rd_out;
  endsequence
  sequence s_high_byte;
    vec_rd_out && vec_addr_out == 16'h0001 ##1 !vec_rd_out && !ready_out;
  endsequence
  a_vector_order: assert property (
    $fell(rst_in) |-> s_low_byte ##1 s_high_byte ##1 ready_out) else $error("vector order");
  a_vector_load: assert property (
    $rose(ready_out) |-> next_instruction_pointer_out == {$past(rd_data_in), $past(rd_data_in, 3)})
    else $error("vector value");
  a_reset_values: assert property ($fell(rst_in) |-> processor_status_word_out == 8'h02
    && memory_size_select_out == 8'hCF) else $error("reset values");
  // ****************************************************************
  // Pointer, status word and size setting
  // ****************************************************************
  a_pc_advance: assert property (ready_out && ctrl_in.advance && !ctrl_in.branch |=>
    next_instruction_pointer_out == $past(next_instruction_pointer_out) + 16'($past(ctrl_in.length)))
    else $error("pointer advance");
  a_pc_branch: assert property (ready_out && ctrl_in.branch |=>
    next_instruction_pointer_out == $past(ctrl_in.target)) else $error("pointer branch");
  a_psw_restore: assert property (ready_out && ctrl_in.psw_restore |=>
    processor_status_word_out == $past(ctrl_in.stack_data)) else $error("status restore");
  a_psw_snapshot: assert property (ready_out && (ctrl_in.psw_save || ctrl_in.irq_accept) |=>
    psw_push_data_out == $past(processor_status_word_out)) else $error("status save");
  a_size_write: assert property (mss_write_in |=>
    memory_size_select_out == $past(mss_data_in)) else $error("size write");
  // ****************************************************************
  // Decode
  // ****************************************************************
  a_bank_fetch: assert property (req_in.valid && req_in.fetch && req_in.addr[15:5] == 11'h7F7
    |-> decode_out.fetch_fault && decode_out.region == cmmd_pkg::CMMD_REG_BANK) else $error("bank");
  a_sfr_window: assert property (req_in.valid && req_in.addr[15:8] == 8'hFF
    |-> decode_out.region == cmmd_pkg::CMMD_REG_SFR) else $error("sfr window");
  a_flash_block: assert property (req_in.valid
    |-> decode_out.flash_block == req_in.addr[14:10]) else $error("flash block");
endmodule
bind cmmd_decoder cmmd_assertions chk_u (.ref_clk_in, .rst_in, .req_in, .ctrl_in, .mss_write_in,
  .mss_data_in, .rd_data_in, .decode_out, .vec_rd_out, .vec_addr_out, .ready_out,
  .next_instruction_pointer_out, .processor_status_word_out, .psw_push_data_out,
  .memory_size_select_out);
`default_nettype wire

// ---- dv/cmmd_seq_model.sv ----
/*
  Sequencer-side model: answers reset vector reads from a fixed vector.
  Assumes vec_rd_in and vec_addr_in come from the decoder on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cmmd_seq_model #(
  parameter logic [15:0] VEC = 16'h0000
) (
  input  wire logic        clk_in,
  input  wire logic        vec_rd_in,
  input  wire logic [15:0] vec_addr_in,
  output var  logic [7:0]  rd_data_out
);
  // Byte stands one cycle after the request, then toggles so stale data is not reused
  always @(posedge clk_in) begin
    if (vec_rd_in) begin
      rd_data_out <= vec_addr_in[0] ? VEC[15:8] : VEC[7:0];
    end else begin
      rd_data_out <= ~rd_data_out;
    end
  end
endmodule
`default_nettype wire

// ---- dv/test_cpu_memory_map_decoder.sv ----
/*
  Testbench for the memory map decoder: vector load, size codes, decode, pointer, status word.
  Assumes the sequencer model answers vector reads.
*/
`timescale 1ns/1ns
`default_nettype none
module test_cpu_memory_map_decoder;
  localparam logic [15:0] VEC      = 16'h2A5C;
  localparam logic [7:0]  CODE [4] = '{8'h42, 8'h04, 8'hC6, 8'hC8};
  localparam logic [15:0] ROME [4] = '{16'h1FFF, 16'h3FFF, 16'h5FFF, 16'h7FFF};
  localparam logic [15:0] RAMS [4] = '{16'hFD00, 16'hFC00, 16'hFB00, 16'hFB00};
  logic                   clk;
  logic                   rst;
  logic                   swap;
  logic                   mss_wr;
  logic [7:0]             mss_d;
  logic [7:0]             rd;
  cmmd_pkg::cmmd_req_t    req;
  cmmd_pkg::cmmd_ctrl_t   ctrl;
  cmmd_pkg::cmmd_decode_t dec_o;
  logic                   vrd;
  logic [15:0]            vaddr;
  logic                   rdy;
  logic [15:0]            pc;
  logic [7:0]             processor_status_word;
  logic [7:0]             push;
  logic [7:0]             mss;
  int                     error_cnt = 0;
  int                     total_checks = 0;

  cmmd_decoder dut_u (.ref_clk_in(clk), .rst_in(rst), .req_in(req), .ctrl_in(ctrl),
    .boot_swap_in(swap), .mss_write_in(mss_wr), .mss_data_in(mss_d), .rd_data_in(rd),
    .decode_out(dec_o), .vec_rd_out(vrd), .vec_addr_out(vaddr), .ready_out(rdy),
    .next_instruction_pointer_out(pc), .processor_status_word_out(processor_status_word),
    .psw_push_data_out(push), .memory_size_select_out(mss));
  cmmd_seq_model #(.VEC(VEC)) seq_u (.clk_in(clk), .vec_rd_in(vrd), .vec_addr_in(vaddr),
    .rd_data_out(rd));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task chb(input string n, input logic s, input logic e);
    chk(n, {15'h0, s}, {15'h0, e});
  endtask
  task stop_test;
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task dec(input logic [15:0] a, input logic f, input logic w);
    @(negedge clk);
    req = '{valid: 1'h1, fetch: f, write: w, addr: a};
    #1;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset(input int n);
    rst = 1'h1;
    repeat (n) @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i < 10 && rdy !== 1'h1; i++) @(negedge clk);
    chb("ready", rdy, 1'h1);
    chk("pointer", pc, VEC);
    chk("status", 16'(processor_status_word), 16'h0002);
    chk("size", 16'(mss), 16'h00CF);
  endtask
  task t_pc;
    logic [15:0] e;
    e = VEC;
    for (int l = 1; l < 4; l++) begin
      ctrl.advance = 1'h1;
      ctrl.length = 2'(l);
      @(negedge clk);
      e = e + 16'(l);
      chk("pointer", pc, e);
    end
    ctrl.branch = 1'h1;
    ctrl.target = 16'h0800;
    @(negedge clk);
    ctrl = '0;
    chk("branch", pc, 16'h0800);
  endtask
  task t_psw;
    ctrl.psw_write = 1'h1;
    ctrl.psw_data = 8'hA5;
    @(negedge clk);
    chk("status", 16'(processor_status_word), 16'h00A5);
    ctrl.psw_save = 1'h1;
    ctrl.psw_data = 8'h3C;
    @(negedge clk);
    chk("push", 16'(push), 16'h00A5);
    ctrl = '0;
    ctrl.irq_accept = 1'h1;
    @(negedge clk);
    chk("push", 16'(push), 16'h003C);
    ctrl = '0;
    ctrl.psw_restore = 1'h1;
    ctrl.psw_write = 1'h1;
    ctrl.stack_data = 8'h81;
    @(negedge clk);
    ctrl = '0;
    chk("status", 16'(processor_status_word), 16'h0081);
  endtask
  task t_map;
    for (int i = 0; i < 4; i++) begin
      mss_wr = 1'h1;
      mss_d = CODE[i];
      @(negedge clk);
      mss_wr = 1'h0;
      chk("size", 16'(mss), 16'(CODE[i]));
      dec(ROME[i], 1'h1, 1'h0);
      chb("rom_top", dec_o.implemented, 1'h1);
      dec(ROME[i] + 16'h0001, 1'h0, 1'h0);
      chb("rom_over", dec_o.implemented, 1'h0);
      dec(RAMS[i], 1'h0, 1'h1);
      chb("ram_low", dec_o.write_enable, 1'h1);
      dec(RAMS[i] - 16'h0001, 1'h0, 1'h1);
      chb("ram_under", dec_o.write_enable, 1'h0);
      @(negedge clk);
    end
    dec(16'h003E, 1'h0, 1'h0);
    chb("vector", dec_o.vector_area, 1'h1);
    dec(16'h0040, 1'h0, 1'h0);
    chb("tcall", dec_o.table_call_area, 1'h1);
    chb("vector", dec_o.vector_area, 1'h0);
    dec(16'h0085, 1'h0, 1'h0);
    chb("secid", dec_o.security_id_area, 1'h1);
    @(negedge clk);
    swap = 1'h1;
    dec(16'h1084, 1'h0, 1'h0);
    chb("option", dec_o.option_area, 1'h1);
    dec(16'h108E, 1'h0, 1'h0);
    chb("secid", dec_o.security_id_area, 1'h1);
    @(negedge clk);
    swap = 1'h0;
    dec(16'h0FFF, 1'h0, 1'h0);
    chb("scall", dec_o.short_call_area, 1'h1);
    dec(16'h7C00, 1'h0, 1'h0);
    chk("block", 16'(dec_o.flash_block), 16'h001F);
    dec(16'hFEE0, 1'h1, 1'h0);
    chb("fault", dec_o.fetch_fault, 1'h1);
    chk("bank", 16'(dec_o.reg_bank), 16'h0003);
    dec(16'hFEF8, 1'h0, 1'h1);
    chk("bank", 16'(dec_o.reg_bank), 16'h0000);
    chb("bank_we", dec_o.write_enable, 1'h1);
    dec(16'hFF00, 1'h0, 1'h0);
    chk("region", 16'(dec_o.region), 16'(cmmd_pkg::CMMD_REG_SFR));
  endtask

  initial begin
    rst = 1'h1;
    swap = 1'h0;
    mss_wr = 1'h0;
    mss_d = 8'h00;
    req = '0;
    ctrl = '0;
    @(negedge clk);
    t_reset(20);
    t_pc;
    t_psw;
    t_map;
    @(negedge clk);
    t_reset(2);
    stop_test;
  end
  initial begin
    #5000;
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
